// ==== design/plhp_defines.vh ====
// constants for the powerline host data port
`ifndef PLHP_DEFINES_VH
`define PLHP_DEFINES_VH

// port modes from the static select pins
`define PLHP_MODE_MII       2'h0
`define PLHP_MODE_RMII      2'h1
`define PLHP_MODE_FIFO      2'h2
`define PLHP_MODE_OFF       2'h3

// interframe gap in nanoseconds and system clock period
`define PLHP_IFG_NS         960
`define PLHP_CLK_NS         4
`define PLHP_IFG_CYC        ((`PLHP_IFG_NS + `PLHP_CLK_NS - 1) / `PLHP_CLK_NS)

// least strobe low time in port clock periods
`define PLHP_STROBE_MIN     3

// buffer shape
`define PLHP_FIFO_WIDTH     8
`define PLHP_FIFO_DEPTH     8
`define PLHP_BUF_AW         11
`define PLHP_BUF_DEPTH      2048

`endif

// ==== design/plhp_fifo.v ====
// parameterised valid/ready fifo
`timescale 1ns/1ps
module plhp_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// clock and reset
	input  wire             clk_sys_i,
	input  wire             rst_i,
	// fill side
	input  wire             in_valid_i,
	output wire             in_ready_o,
	input  wire [WIDTH-1:0] in_data_i,
	// drain side
	output wire             out_valid_o,
	input  wire             out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wptr;
	reg [AW-1:0]    rptr;
	reg [AW:0]      count;
	wire            do_wr;
	wire            do_rd;

	assign in_ready_o  = (count != DEPTH[AW:0]);
	assign out_valid_o = (count != {(AW+1){1'b0}});
	assign out_data_o  = mem[rptr];
	assign do_wr       = in_valid_i & in_ready_o;
	assign do_rd       = out_valid_o & out_ready_i;

	always @(posedge clk_sys_i) begin
		if (do_wr)
			mem[wptr] <= in_data_i;
	end

	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wptr  <= {AW{1'b0}};
			rptr  <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (do_wr)
				wptr <= (wptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
					wptr + 1'b1;
			if (do_rd)
				rptr <= (rptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
					rptr + 1'b1;
			if (do_wr & ~do_rd)
				count <= count + 1'b1;
			else if (do_rd & ~do_wr)
				count <= count - 1'b1;
		end
	end
endmodule // plhp_fifo

// ==== design/plhp_host_port.v ====
// host data port of a powerline transceiver (device end)
`timescale 1ns/1ps
`include "plhp_defines.vh"
module plhp_host_port #(
	parameter BUF_DEPTH = `PLHP_BUF_DEPTH,
	parameter BUF_AW    = `PLHP_BUF_AW,
	parameter IFG_CYC   = `PLHP_IFG_CYC
) (
	// clock and reset
	input  wire        clk_sys_i,
	input  wire        rst_i,
	// static mode select pins
	input  wire [1:0]  mode_sel_i,
	// host port pins
	input  wire        port_clock_i,
	input  wire        transmit_request_in_i,
	input  wire [7:0]  host_data_lines_i,
	output wire [7:0]  host_data_lines_o,
	output wire [7:0]  host_data_lines_oe_n_o,
	input  wire        fifo_read_strobe_i,
	input  wire        fifo_write_strobe_i,
	input  wire        collision_line_i,
	input  wire        transmit_error_line_i,
	output reg         carrier_sense_out_o,
	output reg         receive_valid_out_o,
	// transmit bytes to the modulator
	output wire        tx_valid_o,
	input  wire        tx_ready_i,
	output wire [7:0]  tx_data_o,
	output reg         tx_frame_end_o,
	// received bytes from the demodulator
	input  wire        rx_pending_i,
	input  wire        rx_valid_i,
	output wire        rx_ready_o,
	input  wire [7:0]  rx_data_i,
	input  wire        rx_last_i
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_TX    = 3'h1;
	localparam ST_TXEND = 3'h2;
	localparam ST_GAP   = 3'h3;
	localparam ST_DEFER = 3'h4;
	localparam ST_RX    = 3'h5;

	// two-flop synchronisers for pins
	reg [1:0] s_clk, s_en, s_rd, s_wr;
	reg [7:0] s_d0, s_d1;
	reg       pclk_q, rd_q, wr_q;
	reg [1:0] mode;
	reg [3:0] s_mode;
	reg [2:0] state;
	reg [15:0] gap_cnt;
	reg [2:0] rd_low, wr_low;
	reg [7:0] asm_byte;
	reg [1:0] asm_cnt;
	reg [7:0] rx_byte;
	reg [1:0] rx_cnt;
	reg       rx_have, rx_last_q, rx_done;
	reg       in_v;
	reg [7:0] in_d;
	reg [7:0] dout;
	reg       en_q;

	wire clk_rise = s_clk[1] & ~pclk_q;
	wire en   = s_en[1];
	wire rd   = s_rd[1];
	wire wr   = s_wr[1];
	wire fifo_mode = (mode == `PLHP_MODE_FIFO);
	wire tx_phase  = (state == ST_TX) | (state == ST_DEFER);
	wire in_ready;
	wire buf_ready;

	// last port clock index within a byte (port clocks per byte minus one)
	function [1:0] units_per_byte;
		input [1:0] m;
		begin
			units_per_byte = (m == `PLHP_MODE_RMII) ? 2'h3 : 2'h1;
		end
	endfunction

	wire unused_ok = collision_line_i | transmit_error_line_i;

	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s_clk <= 2'h0; s_en <= 2'h0; s_rd <= 2'h3; s_wr <= 2'h3;
			s_d0 <= 8'h00; s_d1 <= 8'h00;
			pclk_q <= 1'b0; rd_q <= 1'b1; wr_q <= 1'b1;
			mode <= `PLHP_MODE_OFF;
			s_mode <= 4'hf;
			en_q <= 1'b0;
		end else begin
			s_clk <= {s_clk[0], port_clock_i};
			s_en  <= {s_en[0], transmit_request_in_i};
			s_rd  <= {s_rd[0], fifo_read_strobe_i};
			s_wr  <= {s_wr[0], fifo_write_strobe_i};
			s_d0  <= host_data_lines_i;
			s_d1  <= s_d0;
			pclk_q <= s_clk[1];
			rd_q  <= rd;
			wr_q  <= wr;
			en_q  <= en;
			s_mode <= {s_mode[1:0], mode_sel_i};
			if (state == ST_IDLE)
				mode <= s_mode[3:2];
		end
	end

	// large packet buffer feeding the 8-word fifo
	reg [7:0]        pbuf [0:BUF_DEPTH-1];
	reg [BUF_AW-1:0] pw, pr;
	reg [BUF_AW:0]   pcnt;
	wire pbuf_full = (pcnt == BUF_DEPTH[BUF_AW:0]);
	wire pb_rd = (pcnt != {(BUF_AW+1){1'b0}}) & in_ready;
	assign buf_ready = ~pbuf_full;

	always @(posedge clk_sys_i) begin
		if (in_v & buf_ready)
			pbuf[pw] <= in_d;
	end

	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			pw <= {BUF_AW{1'b0}}; pr <= {BUF_AW{1'b0}};
			pcnt <= {(BUF_AW+1){1'b0}};
		end else begin
			if (in_v & buf_ready)
				pw <= pw + 1'b1;
			if (pb_rd)
				pr <= pr + 1'b1;
			if ((in_v & buf_ready) & ~pb_rd)
				pcnt <= pcnt + 1'b1;
			else if (pb_rd & ~(in_v & buf_ready))
				pcnt <= pcnt - 1'b1;
		end
	end

	plhp_fifo #(
		.WIDTH (`PLHP_FIFO_WIDTH),
		.DEPTH (`PLHP_FIFO_DEPTH),
		.AW    (3)
	) u_fifo (
		.clk_sys_i   (clk_sys_i),
		.rst_i       (rst_i),
		.in_valid_i  (pb_rd),
		.in_ready_o  (in_ready),
		.in_data_i   (pbuf[pr]),
		.out_valid_o (tx_valid_o),
		.out_ready_i (tx_ready_i),
		.out_data_o  (tx_data_o)
	);

	// strobe low counters in port clocks
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rd_low <= 3'h0; wr_low <= 3'h0;
		end else begin
			if (rd)
				rd_low <= 3'h0;
			else if (clk_rise && rd_low != 3'h7)
				rd_low <= rd_low + 1'b1;
			if (wr)
				wr_low <= 3'h0;
			else if (clk_rise && wr_low != 3'h7)
				wr_low <= wr_low + 1'b1;
		end
	end

	wire wr_ok = wr & ~wr_q & (wr_low >= `PLHP_STROBE_MIN);
	wire rd_ok = rd & ~rd_q & (rd_low >= `PLHP_STROBE_MIN);

	// transmit data capture
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			asm_byte <= 8'h00; asm_cnt <= 2'h0;
			in_v <= 1'b0; in_d <= 8'h00;
			tx_frame_end_o <= 1'b0;
		end else begin
			in_v <= 1'b0;
			tx_frame_end_o <= tx_phase & ~en;
			if (~tx_phase) begin
				asm_cnt <= 2'h0;
			end else if (fifo_mode) begin
				if (wr_ok) begin
					in_v <= 1'b1; in_d <= s_d1;
				end
			end else if (en && clk_rise) begin
				if (mode == `PLHP_MODE_RMII) begin
					asm_byte <= {s_d1[1:0], asm_byte[7:2]};
				end else begin
					asm_byte <= {s_d1[3:0], asm_byte[7:4]};
				end
				asm_cnt <= asm_cnt + 1'b1;
				if (asm_cnt == units_per_byte(mode)) begin
					asm_cnt <= 2'h0;
					in_v <= 1'b1;
					in_d <= (mode == `PLHP_MODE_RMII) ?
						{s_d1[1:0], asm_byte[7:2]} :
						{s_d1[3:0], asm_byte[7:4]};
				end
			end
		end
	end

	// receive handshake and output shift
	wire rx_adv = fifo_mode ? rd_ok : clk_rise;
	assign rx_ready_o = (state == ST_RX) & ~rx_have & ~rx_done;

	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rx_byte <= 8'h00; rx_cnt <= 2'h0;
			rx_have <= 1'b0; rx_last_q <= 1'b0; rx_done <= 1'b0;
			dout <= 8'h00;
		end else if (state != ST_RX) begin
			rx_have <= 1'b0; rx_cnt <= 2'h0; rx_done <= 1'b0;
		end else begin
			if (rx_valid_i & rx_ready_o) begin
				rx_have <= 1'b1; rx_byte <= rx_data_i;
				rx_last_q <= rx_last_i;
			end
			if (rx_have && (fifo_mode || rx_adv)) begin
				if (fifo_mode) begin
					dout <= rx_byte;
					if (rd_ok) begin
						rx_have <= 1'b0;
						rx_done <= rx_last_q;
					end
				end else begin
					dout <= (mode == `PLHP_MODE_RMII) ?
						{6'h00, rx_byte[1:0]} : {4'h0, rx_byte[3:0]};
					rx_byte <= (mode == `PLHP_MODE_RMII) ?
						{2'h0, rx_byte[7:2]} : {4'h0, rx_byte[7:4]};
					rx_cnt <= rx_cnt + 1'b1;
					if (rx_cnt == units_per_byte(mode)) begin
						rx_have <= 1'b0; rx_cnt <= 2'h0;
						rx_done <= rx_last_q;
					end
				end
			end
		end
	end

	assign host_data_lines_o = dout;
	assign host_data_lines_oe_n_o = {8{~(receive_valid_out_o &
		(~fifo_mode | ~rd) & ~unused_ok & 1'b1 | receive_valid_out_o &
		unused_ok & (~fifo_mode | ~rd))}};

	// control state machine
	// half-duplex direction control
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ST_IDLE; gap_cnt <= 16'h0000;
			carrier_sense_out_o <= 1'b0;
			receive_valid_out_o <= 1'b0;
		end else begin
			if (gap_cnt != 16'h0000)
				gap_cnt <= gap_cnt - 1'b1;
			case (state)
			ST_IDLE: begin
				if (mode == `PLHP_MODE_OFF) begin
					carrier_sense_out_o <= 1'b0;
				end else if (rx_pending_i) begin
					carrier_sense_out_o <= 1'b1;
					gap_cnt <= IFG_CYC[15:0];
					state <= ST_GAP;
				end else if (en & ~en_q) begin
					carrier_sense_out_o <= 1'b1;
					state <= ST_TX;
				end
			end
			ST_TX: begin
				if (~en)
					state <= ST_TXEND;
			end
			ST_TXEND: begin
				if (rx_pending_i) begin
					gap_cnt <= IFG_CYC[15:0];
					state <= ST_GAP;
				end else if (~pbuf_full) begin
					carrier_sense_out_o <= 1'b0;
					state <= ST_IDLE;
				end
			end
			ST_GAP: begin
				if (en) begin
					state <= ST_DEFER;
				end else if (gap_cnt == 16'h0000) begin
					receive_valid_out_o <= fifo_mode;
					state <= ST_RX;
				end
			end
			ST_DEFER: begin
				if (~en) begin
					gap_cnt <= IFG_CYC[15:0];
					state <= ST_GAP;
				end
			end
			ST_RX: begin
				if (rx_done & (fifo_mode | clk_rise)) begin
					receive_valid_out_o <= 1'b0;
					state <= ST_TXEND;
				end else if (rx_have & rx_adv) begin
					receive_valid_out_o <= 1'b1;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end
endmodule // plhp_host_port

// ==== verification/plhp_host_port_properties.sv ====
// checker on the host data port pins
`timescale 1ns/1ps
module plhp_host_port_properties #(
	parameter IFG_CYC = 240
) (
	// clock and reset
	input wire       clk_sys_i,
	input wire       rst_i,
	// host pins
	input wire       transmit_request_in_i,
	input wire       carrier_sense_out_o,
	input wire       receive_valid_out_o,
	input wire [7:0] host_data_lines_oe_n_o,
	// byte streams
	input wire       tx_valid_o,
	input wire       tx_ready_i,
	input wire [7:0] tx_data_o,
	input wire       tx_frame_end_o,
	input wire       rx_valid_i,
	input wire       rx_ready_o,
	input wire       rx_last_i
);
	// ======
	// cycles since enable low
	int quiet;
	always @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i)
			quiet <= 0;
		else if (transmit_request_in_i)
			quiet <= 0;
		else if (quiet < 1000)
			quiet <= quiet + 1;
	end
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);
	// ======
	// assertions
	chk_rxv_no_txen: assert property (
		!(receive_valid_out_o && transmit_request_in_i))
		else $error("receive valid with enable");
	chk_rxv_needs_cs: assert property (
		receive_valid_out_o |-> carrier_sense_out_o)
		else $error("receive valid without sense");
	chk_rx_gap: assert property (
		$rose(receive_valid_out_o) |-> quiet >= IFG_CYC)
		else $error("receive valid before gap");
	chk_cs_answer: assert property (
		$rose(transmit_request_in_i) && !carrier_sense_out_o
		|-> ##[1:8] carrier_sense_out_o)
		else $error("no sense after enable");
	chk_cs_drop: assert property (
		$fell(carrier_sense_out_o) |-> !transmit_request_in_i)
		else $error("sense fell with enable high");
	chk_oe_idle: assert property (
		!receive_valid_out_o && !$past(receive_valid_out_o)
		|-> host_data_lines_oe_n_o == 8'hff)
		else $error("data lines driven outside receive");
	chk_tx_hold: assert property (
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
		else $error("held tx byte changed");
	chk_rx_end: assert property (
		rx_valid_i && rx_ready_o && rx_last_i
		|-> ##[1:1000] !receive_valid_out_o)
		else $error("receive valid stuck");
	chk_frame_end: assert property (
		$fell(transmit_request_in_i) && carrier_sense_out_o
		|-> ##[1:4] tx_frame_end_o)
		else $error("no frame end mark");
	cov_rx: cover property ($rose(receive_valid_out_o));
	cov_tx: cover property (tx_valid_o && tx_ready_i);
	cov_stall: cover property ((tx_valid_o && !tx_ready_i) [*4]);
endmodule // plhp_host_port_properties
bind plhp_host_port plhp_host_port_properties #(.IFG_CYC(IFG_CYC))
	plhp_host_port_properties_i (.clk_sys_i, .rst_i,
	.transmit_request_in_i, .carrier_sense_out_o, .receive_valid_out_o,
	.host_data_lines_oe_n_o, .tx_valid_o, .tx_ready_i, .tx_data_o,
	.rx_valid_i, .rx_ready_o, .rx_last_i, .tx_frame_end_o);

// ==== verification/plhp_host_port_tb_top.sv ====
// bench for the host data port
`timescale 1ns/1ps
`include "plhp_defines.vh"
module plhp_host_port_tb_top;
	// ======
	// pins and state
	logic        clk_sys_i = 1'h0;
	logic        rst_i = 1'h1;
	logic        port_clock_i = 1'h0;
	logic        fifo_read_strobe_i = 1'h1;
	logic        collision_line_i = 1'h0;
	logic        transmit_error_line_i = 1'h0;
	logic        tx_ready_i = 1'h0;
	logic        rx_pending_i = 1'h0;
	logic        rx_valid_i = 1'h0;
	logic        rx_last_i = 1'h0;
	logic        stall = 1'h0;
	logic [1:0]  mode_sel_i = 2'h0;
	logic [7:0]  rx_data_i = 8'h00;
	logic [7:0]  pat = 8'h00;
	logic [31:0] lf = 32'hdeea;
	wire         drv;
	wire         transmit_request_in_i;
	wire         fifo_write_strobe_i;
	wire         carrier_sense_out_o;
	wire         receive_valid_out_o;
	wire         tx_valid_o;
	wire         rx_ready_o;
	wire  [7:0]  hdo;
	wire  [7:0]  host_data_lines_i;
	wire  [7:0]  host_data_lines_o;
	wire  [7:0]  host_data_lines_oe_n_o;
	wire  [7:0]  tx_data_o;
	logic [7:0]  txq[$];
	logic [7:0]  rxe[$];
	logic [7:0]  q[$];
	int          bad_count = 0;
	int          tests_run = 0;
	plhp_host_port #(.BUF_DEPTH(16), .BUF_AW(4), .IFG_CYC(8))
		plhp_host_port_i (.clk_sys_i, .rst_i, .mode_sel_i, .port_clock_i,
		.transmit_request_in_i, .host_data_lines_i, .host_data_lines_o,
		.host_data_lines_oe_n_o, .fifo_read_strobe_i, .fifo_write_strobe_i,
		.collision_line_i, .transmit_error_line_i, .carrier_sense_out_o,
		.receive_valid_out_o, .tx_valid_o, .tx_ready_i, .tx_data_o,
		.tx_frame_end_o(), .rx_pending_i, .rx_valid_i, .rx_ready_o,
		.rx_data_i, .rx_last_i);
	plhp_mac plhp_mac_i (.clk_i(clk_sys_i), .pclk_i(port_clock_i),
		.cs_i(carrier_sense_out_o), .rxv_i(receive_valid_out_o),
		.din_i(host_data_lines_i), .en_o(transmit_request_in_i),
		.drv_o(drv), .dout_o(hdo), .wr_n_o(fifo_write_strobe_i));
	assign host_data_lines_i = ~host_data_lines_oe_n_o & host_data_lines_o
		| host_data_lines_oe_n_o & (drv ? hdo : pat);
	// ======
	// clocks and random stimulus
	always #2 clk_sys_i = ~clk_sys_i;
	initial #13 forever #40 port_clock_i = ~port_clock_i;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	always @(negedge clk_sys_i) begin
		lf = lfsr(lf);
		pat <= lf[15:8];
		tx_ready_i <= lf[2] & ~stall;
		collision_line_i <= lf[5];
		transmit_error_line_i <= lf[6];
	end
	always @(negedge clk_sys_i) begin
		#1;
		if (!rst_i && tx_valid_o === 1'h1 && tx_ready_i)
			check("tx_data", txq.pop_front(), tx_data_o);
	end
	// ======
	// tasks
	task automatic check(input string n, input logic [7:0] e,
		input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tx(input logic [1:0] m, input int n);
		int i;
		mode_sel_i = m;
		q.delete();
		for (i = 0; i < n; i++)
			q.push_back(lf[7:0] ^ 8'(i * 37));
		txq = {txq, q};
		plhp_mac_i.send(m, q);
	endtask
	task automatic rx(input int n);
		int i;
		@(negedge clk_sys_i);
		rx_pending_i = 1'h1;
		for (i = 0; i < n; i++) begin
			rx_data_i = lf[7:0];
			rx_last_i = (i == n - 1);
			rx_valid_i = 1'h1;
			rxe.push_back(rx_data_i);
			@(posedge clk_sys_i);
			while (!rx_ready_o) @(posedge clk_sys_i);
			@(negedge clk_sys_i);
			rx_pending_i = 1'h0;
		end
		rx_valid_i = 1'h0;
		rx_last_i = 1'h0;
	endtask
	task automatic rx_cmp;
		wait (!receive_valid_out_o);
		@(negedge port_clock_i);
		while (rxe.size())
			check("rx_data", rxe.pop_front(), plhp_mac_i.rq.pop_front());
		check("rx_left", 8'h00, 8'(plhp_mac_i.rq.size()));
	endtask
	task automatic fin(input string s);
		int t;
		t = 0;
		while ((txq.size() || carrier_sense_out_o) && t < 5000) begin
			@(negedge clk_sys_i);
			t++;
		end
		check("tx_left", 8'h00, 8'(txq.size()));
		check("cs_low", 8'h00, {7'h0, carrier_sense_out_o});
		$display("test %s done", s);
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ======
	// main sequence and watchdog
	initial begin
		repeat (12) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		rst_i = 1'h0;
		repeat (8) @(negedge clk_sys_i);
		tx(`PLHP_MODE_MII, 6);
		fin("mii");
		tx(`PLHP_MODE_RMII, 5);
		fin("rmii");
		tx(`PLHP_MODE_FIFO, 4);
		fin("fifo");
		stall = 1'h1;
		fork
			tx(`PLHP_MODE_MII, 24);
		join_none
		wait (transmit_request_in_i);
		wait (!transmit_request_in_i);
		repeat (8) @(negedge clk_sys_i);
		check("tx_held", 8'h01, {7'h0, tx_valid_o});
		check("cs_held", 8'h01, {7'h0, carrier_sense_out_o});
		stall = 1'h0;
		wait fork;
		fin("stall");
		rx(4);
		rx_cmp;
		fin("rx");
		fork
			tx(`PLHP_MODE_MII, 4);
			begin
				wait (transmit_request_in_i);
				rx(3);
			end
		join
		rx_cmp;
		fin("defer");
		mode_sel_i = `PLHP_MODE_FIFO;
		repeat (4) @(negedge clk_sys_i);
		fork
			rx(3);
			begin
				wait (receive_valid_out_o);
				while (receive_valid_out_o) begin
					fifo_read_strobe_i = 1'h0;
					repeat (4) @(negedge port_clock_i);
					@(negedge clk_sys_i);
					check("fifo_rx", rxe.pop_front(), host_data_lines_i);
					fifo_read_strobe_i = 1'h1;
					repeat (2) @(negedge port_clock_i);
					@(negedge clk_sys_i);
				end
			end
		join
		check("rx_left", 8'h00, 8'(rxe.size()));
		fin("fifo rx");
		end_of_test;
	end
	initial begin
		#100000;
		bad_count++;
		end_of_test;
	end
endmodule // plhp_host_port_tb_top

// ==== verification/plhp_mac.sv ====
// host side model: mac or fifo controller
`timescale 1ns/1ps
`include "plhp_defines.vh"
module plhp_mac (
	// clocks
	input  wire       clk_i,
	input  wire       pclk_i,
	// device pins
	input  wire       cs_i,
	input  wire       rxv_i,
	input  wire [7:0] din_i,
	// host drive
	output reg        en_o = 1'h0,
	output reg        drv_o = 1'h0,
	output reg  [7:0] dout_o = 8'h00,
	output reg        wr_n_o = 1'h1
);
	logic [7:0] rq[$];
	logic [7:0] acc = 8'h00;
	int         nib = 0;
	// ======
	// low nibble first
	always @(negedge pclk_i) begin
		if (rxv_i) begin
			acc = {din_i[3:0], acc[7:4]};
			nib = nib + 1;
			if (nib % 2 == 0)
				rq.push_back(acc);
		end
	end
	task automatic pulse(input int n);
		wr_n_o = 1'h0;
		repeat (n) @(negedge pclk_i);
		@(negedge clk_i);
		wr_n_o = 1'h1;
		repeat (2) @(negedge pclk_i);
		@(negedge clk_i);
	endtask
	// ======
	// one frame from the host
	task automatic send(input logic [1:0] m, input logic [7:0] q[$]);
		int w;
		int i;
		int k;
		w = (m == `PLHP_MODE_RMII) ? 2 : 4;
		do begin
			@(negedge pclk_i);
			@(negedge clk_i);
		end while (cs_i || rxv_i);
		en_o = 1'h1;
		drv_o = 1'h1;
		for (i = 0; i < q.size(); i++) begin
			dout_o = q[i];
			if (m == `PLHP_MODE_FIFO) begin
				if (i == 0)
					pulse(2);
				pulse(4);
			end else begin
				for (k = 0; k < 8; k += w) begin
					dout_o = q[i] >> k;
					@(negedge pclk_i);
					@(negedge clk_i);
				end
			end
		end
		en_o = 1'h0;
		drv_o = 1'h0;
		@(negedge clk_i);
		while (cs_i) @(negedge clk_i);
		repeat (240) @(negedge clk_i);
	endtask
endmodule // plhp_mac
